// [bench/hmv_btn_model.sv]
// Behavioural pair of user push buttons for the volume block.
// Assumes the bench commands presses at the falling clock edge.
`timescale 1ns/100ps
module hmv_btn_model (
  input  wire logic press_dn,
  input  wire logic press_up,
  output logic      down_n,
  output logic      up_n
);
  // Pull-ups hold each pin high when released; the pin goes low only while pressed.
  // The bench keeps each press for as long as a scenario needs.
  assign down_n = ~press_dn;
  assign up_n   = ~press_up;
endmodule // hmv_btn_model

// [bench/tb_top.sv]
// Self-checking bench for the button volume block, with short hold and step counts.
// Assumes the button model drives the pins; the master volume field is read at the ports.
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
  $display("[ERR] %0t got %0h expected %0h", $time, a, b); end end
module tb_top;
  logic       core_clk = 1'b0;
  logic       resetn   = 1'b0;
  logic       press_dn = 1'b0;
  logic       press_up = 1'b0;
  logic       sw_load  = 1'b0;
  logic       sw_mute  = 1'b0;
  logic [4:0] sw_atten = 5'h00;
  wire        volume_down_button_n;
  wire        volume_up_button_n;
  logic [4:0] master_atten;
  logic       master_mute;
  int         fail_count  = 0;
  int         check_count = 0;

  // Small counts: hold 4 cycles, one step every 3 cycles
  hmv_buttons #(.HOLD_CYC(20'h4), .STEP_CYC(25'h3)) hmv_buttons_i (
    .core_clk(core_clk), .resetn(resetn),
    .volume_down_button_n(volume_down_button_n), .volume_up_button_n(volume_up_button_n),
    .sw_load(sw_load), .sw_atten(sw_atten), .sw_mute(sw_mute),
    .master_atten(master_atten), .master_mute(master_mute));
  hmv_btn_model hmv_btn_model_i (.press_dn(press_dn), .press_up(press_up),
    .down_n(volume_down_button_n), .up_n(volume_up_button_n));

  // Clock of 40 ns period
  always #20 core_clk = ~core_clk;

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // Bounded wait, so a stuck level shows as a mismatch rather than a hang
  task automatic wait_atten(input logic [4:0] v, input int lim);
    int i;
    i = 0;
    while (master_atten !== v && i < lim) begin
      cyc(1);
      i++;
    end
  endtask

  task automatic sw_set(input logic [4:0] a, input logic m);
    sw_atten = a;
    sw_mute  = m;
    sw_load  = 1'b1;
    cyc(1);
    sw_load  = 1'b0;
  endtask

  task automatic t_short();
    press_dn = 1'b1;
    cyc(2);
    press_dn = 1'b0;
    cyc(20);
    `CHK(master_atten, 5'h00)
  endtask

  task automatic t_down();
    press_dn = 1'b1;
    cyc(8);
    `CHK(master_atten, 5'h00)
    wait_atten(5'h01, 40);
    `CHK(master_atten, 5'h01)
    cyc(3);
    `CHK(master_atten, 5'h02)
    wait_atten(5'h1E, 200);
    `CHK(master_atten, 5'h1E)
    cyc(10);
    `CHK(master_atten, 5'h1E)
    press_dn = 1'b0;
    cyc(6);
  endtask

  task automatic t_up();
    press_up = 1'b1;
    wait_atten(5'h1D, 40);
    `CHK(master_atten, 5'h1D)
    cyc(3);
    `CHK(master_atten, 5'h1C)
    wait_atten(5'h00, 200);
    cyc(10);
    `CHK(master_atten, 5'h00)
    press_up = 1'b0;
    cyc(6);
  endtask

  task automatic t_mute();
    int i;
    sw_set(5'h05, 1'b0);
    `CHK(master_atten, 5'h05)
    press_dn = 1'b1;
    press_up = 1'b1;
    i = 0;
    while (master_mute !== 1'b1 && i < 30) begin
      cyc(1);
      i++;
    end
    `CHK(master_mute, 1'b1)
    cyc(12);
    `CHK(master_atten, 5'h05)
    press_dn = 1'b0;
    press_up = 1'b0;
    cyc(6);
    // Values past the range end are clipped, not wrapped
    sw_set(5'h1F, 1'b0);
    `CHK(master_atten, 5'h1E)
    `CHK(master_mute, 1'b0)
  endtask

  // Fresh single press leaves mute; a load with the mute bit set mutes at once
  task automatic t_unmute();
    int i;
    sw_set(5'h0A, 1'b1);
    `CHK(master_mute, 1'b1)
    `CHK(master_atten, 5'h0A)
    press_dn = 1'b1;
    i = 0;
    while (master_mute !== 1'b0 && i < 30) begin
      cyc(1);
      i++;
    end
    `CHK(master_mute, 1'b0)
    `CHK(master_atten, 5'h0A)
    press_dn = 1'b0;
    cyc(8);
  endtask

  task automatic complete_run();
    if (fail_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles the scenarios need
  initial begin
    cyc(3000);
    fail_count++;
    complete_run();
  end

  // Main sequence: reset for 3 cycles, then each scenario in turn
  initial begin
    cyc(3);
    resetn = 1'b1;
    cyc(2);
    `CHK(master_atten, 5'h00)
    `CHK(master_mute, 1'b0)
    t_short();
    t_down();
    t_up();
    t_mute();
    t_unmute();
    complete_run();
  end
endmodule // tb_top

// [logic/hmv_btn_if.sv]
// Carries one button between the top block and its qualifier.
// Assumes both ends sit on the same core clock.
`timescale 1ns/100ps
interface hmv_btn_if;
  logic raw_n;     // Button pin, active low, unsynchronised
  logic pressed;   // Qualified press, core clock domain
  modport qual (input raw_n, output pressed);
  modport core (output raw_n, input pressed);
endinterface // hmv_btn_if

// [logic/hmv_buttons.sv]
// Hardware master volume: two push buttons ramp, saturate or mute the level.
// Assumes core_clk is the device reference clock; buttons are raw pins.
`timescale 1ns/100ps
// Operation
// RULE1: Held down button lowers level 1.5 dB/s
// RULE2: Held up button raises level 1.5 dB/s
// RULE3: Press counts only after 25 ms low
// RULE4: Both buttons together mute the output
// RULE5: Level changes visible in master volume field
// RULE6: Attenuation 0 to -45 dB, 1.5 dB steps
// RULE7: All timing derived from reference clock
// RULE8: Ramp saturates at range ends, never wraps
module hmv_buttons
  import hmv_pkg::*;
#(
  parameter logic [HOLD_W-1:0] HOLD_CYC = HOLD_W'(HOLD_CYC_DEF),
  parameter logic [STEP_W-1:0] STEP_CYC = STEP_W'(STEP_CYC_DEF)
) (
  input  wire logic               core_clk,
  input  wire logic               resetn,
  input  wire logic               volume_down_button_n,
  input  wire logic               volume_up_button_n,
  input  wire logic               sw_load,
  input  wire logic [ATTEN_W-1:0] sw_atten,
  input  wire logic               sw_mute,
  output logic      [ATTEN_W-1:0] master_atten,
  output logic                    master_mute
);
  typedef struct packed {
    hmv_mode_e          mode;
    logic [STEP_W-1:0]  cnt;
    logic [ATTEN_W-1:0] atten;
    logic               mute;
  } hmv_top_s;

  hmv_top_s  st_reg;
  hmv_top_s  st_next;
  hmv_mode_e mode_next;
  logic      step;
  logic      down_q;
  logic      up_q;

  hmv_btn_if dn_if ();
  hmv_btn_if up_if ();

  // Pins enter through the qualifiers only
  assign dn_if.raw_n = volume_down_button_n;
  assign up_if.raw_n = volume_up_button_n;
  assign down_q      = dn_if.pressed;
  assign up_q        = up_if.pressed;

  hmv_debounce #(.HOLD_CYC(HOLD_CYC)) u_dn_qual (
    .core_clk (core_clk),
    .resetn   (resetn),
    .btn      (dn_if)
  );

  hmv_debounce #(.HOLD_CYC(HOLD_CYC)) u_up_qual (
    .core_clk (core_clk),
    .resetn   (resetn),
    .btn      (up_if)
  );

  // Button action; both together takes priority over either alone
  always_comb begin
    if (down_q && up_q) begin
      mode_next = HMV_MUTE;                                    // [RULE4]
    end else if (down_q) begin
      mode_next = HMV_DOWN;
    end else if (up_q) begin
      mode_next = HMV_UP;
    end else begin
      mode_next = HMV_IDLE;
    end
  end

  // Step timer restarts on every change of action, so the first step
  // lands one full period after the press is recognised
  // Trade-off: whole 1.5 dB steps keep the rate exact with no fraction
  // counter, at the cost of a coarse ramp the listener can hear
  always_comb begin
    st_next      = st_reg;
    step         = 1'b0;
    st_next.mode = mode_next;
    if (mode_next != st_reg.mode) begin
      st_next.cnt = '0;
    end else if (st_reg.cnt == STEP_CYC - STEP_W'(1)) begin
      st_next.cnt = '0;
      step        = 1'b1;                                      // [RULE7]
    end else begin
      st_next.cnt = st_reg.cnt + STEP_W'(1);
    end
    // Software load first; a button action in the same cycle then applies on top of the loaded values
    if (sw_load) begin
      st_next.atten = (sw_atten > ATTEN_MAX) ? ATTEN_MAX : sw_atten; // [RULE6]
      st_next.mute  = sw_mute;
    end
    case (mode_next)
      HMV_MUTE: begin
        st_next.mute = 1'b1;                                   // [RULE4]
      end
      HMV_DOWN: begin
        // A fresh single press leaves mute, as the user is adjusting again
        if (st_reg.mode != HMV_DOWN) begin
          st_next.mute = 1'b0;
        end
        if (step && st_next.atten < ATTEN_MAX) begin           // [RULE8]
          st_next.atten = st_next.atten + ATTEN_ONE;           // [RULE1]
        end
      end
      HMV_UP: begin
        if (st_reg.mode != HMV_UP) begin
          st_next.mute = 1'b0;
        end
        if (step && st_next.atten > ATTEN_MIN) begin           // [RULE8]
          st_next.atten = st_next.atten - ATTEN_ONE;           // [RULE2]
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '{mode: HMV_IDLE, cnt: '0, atten: ATTEN_RST, mute: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // Master volume field read-back straight from state flops
  assign master_atten = st_reg.atten;                          // [RULE5]
  assign master_mute  = st_reg.mute;                           // [RULE5]

  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_atten_in_range: assert property ( // [RULE6]
    master_atten <= ATTEN_MAX)
    else $error("attenuation beyond -45 dB");
  a_down_step: assert property ( // [RULE1]
    (st_reg.mode == HMV_DOWN && mode_next == HMV_DOWN && step && !sw_load &&
     st_reg.atten < ATTEN_MAX) |=> master_atten == $past(master_atten) + ATTEN_ONE)
    else $error("down step missing");
  a_up_step: assert property ( // [RULE2]
    (st_reg.mode == HMV_UP && mode_next == HMV_UP && step && !sw_load &&
     st_reg.atten > ATTEN_MIN) |=> master_atten == $past(master_atten) - ATTEN_ONE)
    else $error("up step missing");
  a_both_mute: assert property ( // [RULE4]
    (down_q && up_q && !sw_load) |=> master_mute && $stable(master_atten))
    else $error("both buttons did not mute");
  a_sat_bottom: assert property ( // [RULE8]
    (master_atten == ATTEN_MAX && st_reg.mode == HMV_DOWN && !sw_load)
      |=> master_atten == ATTEN_MAX)
    else $error("level wrapped below -45 dB");
  a_sat_top: assert property ( // [RULE8]
    (master_atten == ATTEN_MIN && st_reg.mode == HMV_UP && !sw_load)
      |=> master_atten == ATTEN_MIN)
    else $error("level wrapped above 0 dB");
  a_idle_holds: assert property ( // [RULE5]
    (!step && !sw_load) |=> $stable(master_atten))
    else $error("level changed without cause");
  a_step_period: assert property ( // [RULE7]
    st_reg.cnt <= STEP_CYC - STEP_W'(1))
    else $error("step timer past period");

  // Muted level is frozen while both stay held, and no step sneaks in
  a_mute_freezes: assert property ( // [RULE4]
    (st_reg.mode == HMV_MUTE && mode_next == HMV_MUTE && !sw_load)
      |=> master_mute && $stable(master_atten))
    else $error("level moved while muted");

  // A mute left alone stays; only a press or a load changes it
  a_idle_keeps_mute: assert property ( // [RULE4]
    (mode_next == HMV_IDLE && !sw_load) |=> $stable(master_mute))
    else $error("mute changed with no cause");

  // Timer ticks with no button held must not move the level
  a_idle_no_step: assert property ( // [RULE1]
    (mode_next == HMV_IDLE && !sw_load) |=> $stable(master_atten))
    else $error("level moved with no button held");

  // Fresh single presses take the output out of mute at once
  a_down_unmutes: assert property ( // [RULE1]
    (mode_next == HMV_DOWN && st_reg.mode != HMV_DOWN) |=> !master_mute)
    else $error("down press left output muted");

  a_up_unmutes: assert property ( // [RULE2]
    (mode_next == HMV_UP && st_reg.mode != HMV_UP) |=> !master_mute)
    else $error("up press left output muted");

  // Holding one button only ever moves the level one way
  a_down_monotone: assert property ( // [RULE1]
    (st_reg.mode == HMV_DOWN && mode_next == HMV_DOWN && !sw_load)
      |=> master_atten >= $past(master_atten))
    else $error("level rose while down held");

  a_up_monotone: assert property ( // [RULE2]
    (st_reg.mode == HMV_UP && mode_next == HMV_UP && !sw_load)
      |=> master_atten <= $past(master_atten))
    else $error("level fell while up held");

  // Software writes land in the field; out-of-range values are clipped
  a_load_lands: assert property ( // [RULE5]
    (sw_load && mode_next == HMV_IDLE && sw_atten <= ATTEN_MAX)
      |=> master_atten == $past(sw_atten) && master_mute == $past(sw_mute))
    else $error("software load not reflected");

  a_load_clips: assert property ( // [RULE6]
    (sw_load && mode_next == HMV_IDLE && sw_atten > ATTEN_MAX)
      |=> master_atten == ATTEN_MAX)
    else $error("software load not clipped");

  // Any change of action restarts the step period from zero
  a_timer_restarts: assert property ( // [RULE7]
    (mode_next != st_reg.mode) |=> st_reg.cnt == '0)
    else $error("step timer not restarted");

  a_timer_counts: assert property ( // [RULE7]
    (st_reg.cnt != '0) |-> st_reg.cnt == $past(st_reg.cnt) + STEP_W'(1))
    else $error("step timer skipped a count");

  a_step_rewinds: assert property ( // [RULE7]
    step |=> st_reg.cnt == '0)
    else $error("step timer not rewound after step");
endmodule // hmv_buttons

// [logic/hmv_debounce.sv]
// Synchronises one active-low button pin and qualifies the press by hold time.
// Assumes the pin is asynchronous to core_clk; HOLD_CYC is at least one.
`timescale 1ns/100ps
module hmv_debounce
  import hmv_pkg::*;
#(
  parameter logic [HOLD_W-1:0] HOLD_CYC = HOLD_W'(HOLD_CYC_DEF)
) (
  input  wire logic  core_clk,
  input  wire logic  resetn,
  hmv_btn_if.qual    btn
);
  typedef struct packed {
    logic [SYNC_LEN-1:0] sync;
    logic                stable_n;
    logic [HOLD_W-1:0]   cnt;
    logic                pressed;
  } hmv_deb_s;

  hmv_deb_s st_reg;
  hmv_deb_s st_next;

  // Level changes only once the last two stages agree
  always_comb begin
    st_next      = st_reg;
    st_next.sync = {st_reg.sync[SYNC_LEN-2:0], btn.raw_n};
    if (st_reg.sync[1] == st_reg.sync[2]) begin
      st_next.stable_n = st_reg.sync[2];
    end
    // Press counts only after the full hold; a short dip restarts it
    if (st_reg.stable_n) begin
      st_next.cnt     = '0;
      st_next.pressed = 1'b0;
    end else if (st_reg.cnt == HOLD_CYC - HOLD_W'(1)) begin
      st_next.pressed = 1'b1;                                 // [RULE3]
    end else begin
      st_next.cnt = st_reg.cnt + HOLD_W'(1);                  // [RULE3]
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '{sync: '1, stable_n: 1'b1, cnt: '0, pressed: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign btn.pressed = st_reg.pressed;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_press_after_hold: assert property ( // [RULE3]
    $rose(st_reg.pressed) |-> $past(st_reg.cnt) == HOLD_CYC - HOLD_W'(1))
    else $error("press recognised before hold time");
  a_release_drops: assert property ( // [RULE3]
    st_reg.stable_n |=> !st_reg.pressed && st_reg.cnt == '0)
    else $error("press held after release");
  a_hold_bounded: assert property ( // [RULE7]
    st_reg.cnt <= HOLD_CYC - HOLD_W'(1))
    else $error("hold counter past limit");
endmodule // hmv_debounce

// [logic/hmv_pkg.sv]
// Constants for the hardware master-volume button block.
// Assumes one core clock at CLK_HZ; counts are derived from it here.
package hmv_pkg;
  localparam int unsigned CLK_HZ        = 25_000_000;  // Reference clock rate
  localparam int unsigned HOLD_MS       = 25;          // Least button hold time
  localparam int unsigned STEP_TENTH_DB = 15;          // One level step, 0.1 dB units
  localparam int unsigned RATE_TENTH_DB = 15;          // Ramp rate, 0.1 dB per second
  localparam int unsigned STEP_MS       = STEP_TENTH_DB * 1000 / RATE_TENTH_DB;
  // Plain integer division truncates, no round-up; both divide exactly at this rate
  localparam int unsigned HOLD_CYC_DEF  = (CLK_HZ / 1000 * HOLD_MS + 0) ;
  localparam int unsigned STEP_CYC_DEF  = CLK_HZ / 1000 * STEP_MS;
  localparam int unsigned HOLD_W        = 20;
  localparam int unsigned STEP_W        = 25;
  localparam int unsigned ATTEN_W       = 5;
  // Attenuation in 1.5 dB steps: 0 is 0 dB, 30 is -45 dB
  localparam logic [4:0]  ATTEN_MIN     = 5'h00;
  localparam logic [4:0]  ATTEN_MAX     = 5'h1E;
  localparam logic [4:0]  ATTEN_RST     = 5'h00;
  localparam logic [4:0]  ATTEN_ONE     = 5'h01;
  localparam int unsigned SYNC_LEN      = 3;

  typedef enum logic [1:0] {HMV_IDLE, HMV_DOWN, HMV_UP, HMV_MUTE} hmv_mode_e;
endpackage
